// ==== tb/dlt_counter_timer_props.sv ====
`timescale 1ns/1ps
module dlt_counter_timer_props (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        firstIrq,
  input wire logic        secondIrq,
  input wire logic        firstOverflowPulse,
  input wire logic        secondOverflowPulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic wrDone;
  assign wrDone = wb_ack_o && wb_we_i;
  chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above byte not zero");
  chk_data_held: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data changed without request");
  // Interrupt only moves on an overflow or a register write
  chk_irq_rise: assert property ($rose(firstIrq) |-> firstOverflowPulse || $past(wrDone)
    || $past(wrDone, 2))
    else $error("first irq rose without cause");
  chk_irq_fall: assert property ($fell(firstIrq) |-> $past(wrDone) || $past(wrDone, 2))
    else $error("first irq fell without write");
  chk_irq2_fall: assert property ($fell(secondIrq) |-> $past(wrDone) || $past(wrDone, 2))
    else $error("second irq fell without write");
  cover property (firstOverflowPulse);
  cover property (secondOverflowPulse);
  cover property ($rose(secondIrq));
endmodule // dlt_counter_timer_props

bind dlt_counter_timer dlt_counter_timer_props props_u (
  .clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .firstIrq(firstIrq),
  .secondIrq(secondIrq), .firstOverflowPulse(firstOverflowPulse),
  .secondOverflowPulse(secondOverflowPulse));

// ==== tb/dlt_pin_model.sv ====
`timescale 1ns/1ps
module dlt_pin_model (
  output logic firstCountPin,
  output logic secondCountPin,
  output logic firstGatePin,
  output logic secondGatePin,
  output logic extClockPin
);
  // External clock runs free, off the bus clock's phase
  initial begin
    firstCountPin = 1'b1;
    secondCountPin = 1'b1;
    firstGatePin = 1'b0;
    secondGatePin = 1'b0;
    extClockPin = 1'b0;
    #7;
    forever #50 extClockPin = ~extClockPin;
  end
  // Levels held long enough to pass a two-flop synchroniser
  task automatic fall_edges(input int t, input int n);
    repeat (n) begin
      #110;
      if (t == 0) firstCountPin = 1'b0; else secondCountPin = 1'b0;
      #130;
      if (t == 0) firstCountPin = 1'b1; else secondCountPin = 1'b1;
    end
  endtask
endmodule // dlt_pin_model

// ==== tb/dual_legacy_counter_timer_test.sv ====
`timescale 1ns/1ps
module dual_legacy_counter_timer_test;
  typedef struct { logic [31:0] exp; logic [31:0] mask; int tol; } dlt_note_t;
  logic clock, arst_n, wbCyc, wbStb, wbWe, wbAck, fIrq, sIrq, fPulse, sPulse;
  logic fCnt, sCnt, fGate, sGate, extClk;
  logic [7:0] wbAdr;
  logic [31:0] wbDatI, wbDatO;
  dlt_note_t notes[$];
  dlt_note_t cur;
  int miscompares = 0, compares = 0, pulses0 = 0, pulses1 = 0;
  int pexp[5] = '{16, 49, 4, 6, 195};
  int ptol[5] = '{1, 1, 1, 1, 3};

  dlt_counter_timer dut_u (
    .clock(clock), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .firstCountPin(fCnt), .secondCountPin(sCnt),
    .first_ext_interrupt_pin(fGate), .second_ext_interrupt_pin(sGate),
    .extClockPin(extClk), .firstIrq(fIrq), .secondIrq(sIrq),
    .firstOverflowPulse(fPulse), .secondOverflowPulse(sPulse));
  dlt_pin_model pins (
    .firstCountPin(fCnt), .secondCountPin(sCnt), .firstGatePin(fGate),
    .secondGatePin(sGate), .extClockPin(extClk));

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    compares++;
    if ((^got === 1'bx) || (got > exp + tol) || (got + tol < exp)) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge clock) begin
    if (fPulse === 1'b1) pulses0++;
    if (sPulse === 1'b1) pulses1++;
    if (wbAck === 1'b1 && wbWe === 1'b0) begin
      if (notes.size() != 0) cur = notes.pop_front();
      else cur = '{32'h1, 32'h0, 0};
      chk(wbDatO & cur.mask, cur.exp, cur.tol);
    end
  end

  // ----------------------------------------------------------------
  // Bus and waits
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= {24'h0, d};
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (wbAck !== 1'b1 && i < 50);
    if (i >= 50) begin
      miscompares++;
      close_out();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff, input int tol = 0);
    notes.push_back('{e, m, tol});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wait_pulse(input bit s, input int n);
    int i;
    i = 0;
    while ((s ? pulses1 : pulses0) < n && i < 2000) begin
      @(posedge clock);
      i++;
    end
    chk(32'(i < 2000), 32'h1, 0);
    if (i >= 2000) close_out();
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin : main
    logic [7:0] r;
    int n, m;
    arst_n = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDatI = 32'h0;
    void'($urandom(32'h1855b370));
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    for (int a = 0; a <= 'h24; a += 4) rd(8'(a), 32'h0);
    for (int a = 4; a <= 'h10; a += 4) begin
      r = 8'($urandom);
      wr(8'(a), r);
      rd(8'(a), {24'h0, r});
    end
    // Both timers count pin edges
    wr(dlt_pkg::ADDR_MODE, 8'h55);
    wr(8'h1c, 8'h00);
    wr(dlt_pkg::ADDR_CTRL, 8'h50);
    for (int t = 0; t < 2; t++) begin
      n = 1 + $urandom % 20;
      pins.fall_edges(t, n);
      repeat (6) @(posedge clock);
      rd(8'(8'h14 + 8 * t), 32'(n));
    end
    // 13-bit wrap from 0x1ffe
    wr(dlt_pkg::ADDR_CTRL, 8'h00);
    wr(8'h14, 8'hfe);
    wr(8'h18, 8'hff);
    wr(dlt_pkg::ADDR_MODE, 8'h00);
    wr(dlt_pkg::ADDR_CLKCTL, 8'h04);
    wr(dlt_pkg::ADDR_IRQEN, 8'h02);
    wr(dlt_pkg::ADDR_CTRL, 8'h10);
    wait_pulse(0, pulses0 + 1);
    chk({31'h0, fIrq}, 32'h1, 0);
    wr(dlt_pkg::ADDR_CTRL, 8'h20);
    rd(dlt_pkg::ADDR_CTRL, 32'h20);
    rd(8'h18, 32'h0);
    rd(8'h14, 32'he0, 32'he0);
    wr(dlt_pkg::ADDR_IRQEN, 8'h00);
    @(posedge clock);
    chk({31'h0, fIrq}, 32'h0, 0);
    // Second timer, 16-bit, interrupt masked then unmasked
    wr(8'h1c, 8'hfe);
    wr(8'h20, 8'hff);
    wr(dlt_pkg::ADDR_MODE, 8'h10);
    wr(dlt_pkg::ADDR_CLKCTL, 8'h08);
    wr(dlt_pkg::ADDR_CTRL, 8'h40);
    wait_pulse(1, pulses1 + 1);
    wr(dlt_pkg::ADDR_CTRL, 8'h80);
    chk({31'h0, sIrq}, 32'h0, 0);
    rd(dlt_pkg::ADDR_CTRL, 32'h80);
    rd(8'h20, 32'h0);
    wr(dlt_pkg::ADDR_IRQEN, 8'h08);
    repeat (3) @(posedge clock);
    chk({31'h0, sIrq}, 32'h1, 0);
    wr(dlt_pkg::ADDR_CTRL, 8'h00);
    // Reload mode under the gate pin
    wr(dlt_pkg::ADDR_MODE, 8'h0a);
    wr(dlt_pkg::ADDR_CLKCTL, 8'h04);
    wr(dlt_pkg::ADDR_EXTCFG, 8'h08);
    wr(8'h14, 8'hfa);
    wr(8'h18, 8'hf0);
    wr(dlt_pkg::ADDR_CTRL, 8'h10);
    repeat (20) @(posedge clock);
    rd(8'h14, 32'hfa);
    pins.firstGatePin <= 1'b1;
    wait_pulse(0, pulses0 + 3);
    pins.firstGatePin <= 1'b0;
    repeat (6) @(posedge clock);
    rd(8'h18, 32'hf0);
    rd(8'h14, 32'hf0, 32'hf0);
    rd(dlt_pkg::ADDR_CTRL, 32'h30);
    wr(dlt_pkg::ADDR_EXTCFG, 8'h00);
    wait_pulse(0, pulses0 + 1);
    // Clock sources: four prescaler codes, then system clock
    wr(dlt_pkg::ADDR_CTRL, 8'h00);
    wr(dlt_pkg::ADDR_MODE, 8'h01);
    for (int c = 0; c < 5; c++) begin
      wr(8'h14, 8'h00);
      wr(dlt_pkg::ADDR_CLKCTL, c == 4 ? 8'h04 : 8'(c));
      wr(dlt_pkg::ADDR_CTRL, 8'h10);
      repeat (192) @(posedge clock);
      wr(dlt_pkg::ADDR_CTRL, 8'h00);
      rd(8'h14, 32'(pexp[c]), 32'hff, ptol[c]);
    end
    // Split mode
    n = pulses0;
    m = pulses1;
    wr(dlt_pkg::ADDR_MODE, 8'h13);
    wr(dlt_pkg::ADDR_CLKCTL, 8'h0c);
    wr(8'h14, 8'hfe);
    wr(8'h18, 8'hfe);
    wr(8'h1c, 8'hfe);
    wr(8'h20, 8'hff);
    wr(dlt_pkg::ADDR_CTRL, 8'h10);
    wait_pulse(0, n + 1);
    wait_pulse(1, m + 1);
    rd(dlt_pkg::ADDR_CTRL, 32'h30);
    rd(8'h18, 32'hfe);
    wr(dlt_pkg::ADDR_CTRL, 8'h50);
    repeat (10) @(posedge clock);
    rd(dlt_pkg::ADDR_CTRL, 32'h80, 32'h80);
    wr(dlt_pkg::ADDR_MODE, 8'h33);
    wr(8'h1c, 8'h11);
    repeat (10) @(posedge clock);
    rd(8'h1c, 32'h11);
    wr(dlt_pkg::ADDR_CTRL, 8'h00);
    if (notes.size() != 0) miscompares++;
    close_out();
  end
endmodule // dual_legacy_counter_timer_test

// ==== verilog/dlt_counter_timer.sv ====
`timescale 1ns/1ps

module dlt_counter_timer (
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Pins
  input  wire logic        firstCountPin,
  input  wire logic        secondCountPin,
  input  wire logic        first_ext_interrupt_pin,
  input  wire logic        second_ext_interrupt_pin,
  input  wire logic        extClockPin,
  // Events
  output logic             firstIrq,
  output logic             secondIrq,
  output logic             firstOverflowPulse,
  output logic             secondOverflowPulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            ack;
    logic [7:0]      rdat;
    logic [7:0]      timer_control_reg;
    logic [7:0]      timer_mode_reg;
    logic [7:0]      clock_control_reg;
    logic [7:0]      ext_interrupt_config_reg;
    logic [7:0]      irqEnableReg;
    logic [3:0][7:0] cnt;
    logic [4:0]      sync1;
    logic [4:0]      sync2;
    logic [4:0]      prev;
    logic [5:0]      preCnt;
    logic [2:0]      extDiv;
    logic            irq0;
    logic            irq1;
    logic            ovfPulse0;
    logic            ovfPulse1;
  } dlt_state_t;

  dlt_state_t s_q;
  dlt_state_t s_d;

  // ----------------------------------------------------------------
  // One count step: returns {overflow, high, low}
  // ----------------------------------------------------------------
  function automatic logic [16:0] countStep(input logic [1:0] mode,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [12:0] v13;
    logic [15:0] v16;
    logic [16:0] r;
    v13 = {hi, lo[4:0]};
    v16 = {hi, lo};
    r   = {1'b0, hi, lo};
    case (mode)
      dlt_pkg::MODE_13BIT: begin
        // Upper low-byte bits are left alone; they carry no count
        v13 = v13 + 13'h0001;
        r   = {(v13 == 13'h0000), v13[12:5], lo[7:5], v13[4:0]};
      end
      dlt_pkg::MODE_16BIT: begin
        v16 = v16 + 16'h0001;
        r   = {(v16 == 16'h0000), v16};
      end
      dlt_pkg::MODE_RELOAD: begin
        if (lo == 8'hff) begin
          r = {1'b1, hi, hi};
        end else begin
          r = {1'b0, hi, lo + 8'h01};
        end
      end
      default: begin
        // Split mode low byte: plain 8-bit counter
        r = {(lo == 8'hff), hi, lo + 8'h01};
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0]  pinsNow;
    logic        fall0;
    logic        fall1;
    logic        extRise;
    logic        preTick;
    logic [5:0]  preLast;
    logic [1:0]  pre;
    logic [1:0]  mode0;
    logic [1:0]  mode1;
    logic        split;
    logic        gateOk0;
    logic        gateOk1;
    logic        inc0;
    logic        inc1;
    logic        incHi0;
    logic [16:0] st0;
    logic [16:0] st1;
    logic [8:0]  stHi;
    logic        ovf0;
    logic        ovf1;
    logic        ovfHi;
    logic        setFlag0;
    logic        setFlag1;
    logic        access;
    logic        doWrite;
    logic [7:0]  wbyte;
    logic [7:0]  rd;
    int          idx;

    // Every local gets a value first so no path can leave one stale
    pinsNow  = 5'h00;
    fall0    = 1'b0;
    fall1    = 1'b0;
    extRise  = 1'b0;
    preTick  = 1'b0;
    preLast  = 6'h00;
    pre      = 2'h0;
    mode0    = 2'h0;
    mode1    = 2'h0;
    split    = 1'b0;
    gateOk0  = 1'b0;
    gateOk1  = 1'b0;
    inc0     = 1'b0;
    inc1     = 1'b0;
    incHi0   = 1'b0;
    st0      = 17'h00000;
    st1      = 17'h00000;
    stHi     = 9'h000;
    ovf0     = 1'b0;
    ovf1     = 1'b0;
    ovfHi    = 1'b0;
    setFlag0 = 1'b0;
    setFlag1 = 1'b0;
    access   = 1'b0;
    doWrite  = 1'b0;
    wbyte    = 8'h00;
    rd       = 8'h00;
    idx      = 0;

    s_d     = s_q;
    pinsNow = {extClockPin, second_ext_interrupt_pin, first_ext_interrupt_pin,
               secondCountPin, firstCountPin};
    mode0   = s_q.timer_mode_reg[dlt_pkg::MODE_LSB0 +: 2];
    mode1   = s_q.timer_mode_reg[dlt_pkg::MODE_LSB1 +: 2];
    split   = (mode0 == dlt_pkg::MODE_SPLIT);
    pre     = s_q.clock_control_reg[dlt_pkg::CLK_PRE_LSB +: 2];

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ----------------------------------------------------------------
    // Pins pass two flops; edges are taken from the second and third
    s_d.sync1 = pinsNow;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    fall0   = s_q.prev[0] & ~s_q.sync2[0];
    fall1   = s_q.prev[1] & ~s_q.sync2[1];
    extRise = s_q.sync2[4] & ~s_q.prev[4];

    // ----------------------------------------------------------------
    // Shared prescaler
    // ----------------------------------------------------------------
    case (pre)
      dlt_pkg::PRE_DIV12: preLast = dlt_pkg::DIV12_LAST;
      dlt_pkg::PRE_DIV4:  preLast = dlt_pkg::DIV4_LAST;
      dlt_pkg::PRE_DIV48: preLast = dlt_pkg::DIV48_LAST;
      default:            preLast = dlt_pkg::DIV12_LAST;
    endcase
    preTick = 1'b0;
    if (pre == dlt_pkg::PRE_EXT8) begin
      // External clock is sampled, so it must run below half of clock
      s_d.preCnt = 6'h00;
      if (extRise) begin
        s_d.extDiv = s_q.extDiv + 3'h1;
        preTick    = (s_q.extDiv == dlt_pkg::EXT8_LAST);
      end
    end else begin
      s_d.extDiv = 3'h0;
      // Compare with >= so a smaller divisor chosen mid-count recovers
      if (s_q.preCnt >= preLast) begin
        s_d.preCnt = 6'h00;
        preTick    = 1'b1;
      end else begin
        s_d.preCnt = s_q.preCnt + 6'h01;
      end
    end

    // ----------------------------------------------------------------
    // Run conditions and clock sources
    // ----------------------------------------------------------------
    gateOk0 = ~s_q.timer_mode_reg[dlt_pkg::MODE_FIRST_GATE_ENABLE] |
              (s_q.sync2[2] == s_q.ext_interrupt_config_reg[dlt_pkg::EXT_POL0]);
    gateOk1 = ~s_q.timer_mode_reg[dlt_pkg::MODE_GATE1] |
              (s_q.sync2[3] == s_q.ext_interrupt_config_reg[dlt_pkg::EXT_POL1]);

    // Timer 0 (also split low byte)
    inc0 = s_q.timer_control_reg[dlt_pkg::CTRL_RUN0] & gateOk0 &
           (s_q.timer_mode_reg[dlt_pkg::MODE_CSEL0] ? fall0 :
            (s_q.clock_control_reg[dlt_pkg::CLK_SYS0] ? 1'b1 : preTick));

    // Split high byte: system clock or prescaler only, no count pin, second run bit
    incHi0 = split & s_q.timer_control_reg[dlt_pkg::CTRL_RUN1] &
             (s_q.clock_control_reg[dlt_pkg::CLK_SYS0] ? 1'b1 : preTick);

    // ----------------------------------------------------------------
    // Second timer
    // ----------------------------------------------------------------
    if (split) begin
      // Run control taken over by its mode; no count pin, only system clock or prescaler
      inc1 = (mode1 != dlt_pkg::MODE_SPLIT) &
             (s_q.clock_control_reg[dlt_pkg::CLK_SYS1] ? 1'b1 : preTick);
    end else begin
      inc1 = s_q.timer_control_reg[dlt_pkg::CTRL_RUN1] & gateOk1 &
             (mode1 != dlt_pkg::MODE_SPLIT) &
             (s_q.timer_mode_reg[dlt_pkg::MODE_CSEL1] ? fall1 :
              (s_q.clock_control_reg[dlt_pkg::CLK_SYS1] ? 1'b1 : preTick));
    end

    // ----------------------------------------------------------------
    // Count steps (a run bit never touches the count)
    // ----------------------------------------------------------------
    st0  = countStep(mode0, s_q.cnt[dlt_pkg::CNT_LO0], s_q.cnt[dlt_pkg::CNT_HI0]);
    st1  = countStep(mode1, s_q.cnt[dlt_pkg::CNT_LO1], s_q.cnt[dlt_pkg::CNT_HI1]);
    stHi = {1'b0, s_q.cnt[dlt_pkg::CNT_HI0]} + 9'h001;
    ovf0  = inc0 & st0[16];
    ovf1  = inc1 & st1[16];
    ovfHi = incHi0 & stHi[8];

    if (inc0) begin
      s_d.cnt[dlt_pkg::CNT_LO0] = st0[7:0];
      if (!split) begin
        s_d.cnt[dlt_pkg::CNT_HI0] = st0[15:8];
      end
    end
    if (incHi0) begin
      s_d.cnt[dlt_pkg::CNT_HI0] = stHi[7:0];
    end
    if (inc1) begin
      s_d.cnt[dlt_pkg::CNT_LO1] = st1[7:0];
      s_d.cnt[dlt_pkg::CNT_HI1] = st1[15:8];
    end

    // ----------------------------------------------------------------
    // Overflow events
    // ----------------------------------------------------------------
    setFlag0 = ovf0;
    setFlag1 = split ? ovfHi : ovf1;

    // Overflow strobes for baud and converter triggers
    s_d.ovfPulse0 = ovf0;
    s_d.ovfPulse1 = ovf1;

    // ----------------------------------------------------------------
    // Wishbone classic slave: ack one cycle after request, write at ack
    // ----------------------------------------------------------------
    access  = wb_cyc_i & wb_stb_i;
    doWrite = access & wb_we_i & s_q.ack & wb_sel_i[0];
    wbyte   = wb_dat_i[7:0];
    s_d.ack = access & ~s_q.ack;
    idx     = 0;

    if (doWrite) begin
      case (wb_adr_i)
        dlt_pkg::ADDR_CTRL:   s_d.timer_control_reg = wbyte;
        dlt_pkg::ADDR_MODE:   s_d.timer_mode_reg = wbyte;
        dlt_pkg::ADDR_CLKCTL: s_d.clock_control_reg = wbyte;
        dlt_pkg::ADDR_EXTCFG: s_d.ext_interrupt_config_reg = wbyte;
        dlt_pkg::ADDR_IRQEN:  s_d.irqEnableReg = wbyte;
        default: begin
          // Software write to a count byte beats the count in that cycle
          for (idx = 0; idx < dlt_pkg::NUM_CNT_BYTES; idx++) begin
            if (wb_adr_i == dlt_pkg::ADDR_CNT_BASE + 8'(4 * idx)) begin
              s_d.cnt[idx] = wbyte;
            end
          end
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Flags and interrupt requests
    // ----------------------------------------------------------------
    // Hardware set wins over a software clear in the same cycle
    if (setFlag0) begin
      s_d.timer_control_reg[dlt_pkg::CTRL_FLAG0] = 1'b1;
    end
    if (setFlag1) begin
      s_d.timer_control_reg[dlt_pkg::CTRL_FLAG1] = 1'b1;
    end

    // Interrupt requests gated by the enable register
    s_d.irq0 = s_d.timer_control_reg[dlt_pkg::CTRL_FLAG0] &
               s_q.irqEnableReg[dlt_pkg::IRQEN0];
    s_d.irq1 = s_d.timer_control_reg[dlt_pkg::CTRL_FLAG1] &
               s_q.irqEnableReg[dlt_pkg::IRQEN1];

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Read data is captured in the cycle the ack is raised
    rd = 8'h00;
    case (wb_adr_i)
      dlt_pkg::ADDR_CTRL:   rd = s_q.timer_control_reg;
      dlt_pkg::ADDR_MODE:   rd = s_q.timer_mode_reg;
      dlt_pkg::ADDR_CLKCTL: rd = s_q.clock_control_reg;
      dlt_pkg::ADDR_EXTCFG: rd = s_q.ext_interrupt_config_reg;
      dlt_pkg::ADDR_IRQEN:  rd = s_q.irqEnableReg;
      default: begin
        for (idx = 0; idx < dlt_pkg::NUM_CNT_BYTES; idx++) begin
          if (wb_adr_i == dlt_pkg::ADDR_CNT_BASE + 8'(4 * idx)) begin
            rd = s_q.cnt[idx];
          end
        end
      end
    endcase
    s_d.rdat = (access & ~s_q.ack) ? rd : s_q.rdat;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign wb_ack_o            = s_q.ack;
  assign wb_dat_o            = {24'h000000, s_q.rdat};
  assign firstIrq            = s_q.irq0;
  assign secondIrq           = s_q.irq1;
  assign firstOverflowPulse  = s_q.ovfPulse0;
  assign secondOverflowPulse = s_q.ovfPulse1;

endmodule // dlt_counter_timer

// ==== verilog/dlt_pkg.sv ====
package dlt_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses (one aligned word each, data in bits 7:0)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_MODE     = 8'h04;
  localparam logic [7:0] ADDR_CLKCTL   = 8'h08;
  localparam logic [7:0] ADDR_EXTCFG   = 8'h0c;
  localparam logic [7:0] ADDR_IRQEN    = 8'h10;
  localparam logic [7:0] ADDR_CNT_BASE = 8'h14;
  localparam int         NUM_CNT_BYTES = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN0   = 4;
  localparam int CTRL_FLAG0  = 5;
  localparam int CTRL_RUN1   = 6;
  localparam int CTRL_FLAG1  = 7;
  localparam int MODE_LSB0   = 0;
  localparam int MODE_CSEL0  = 2;
  localparam int MODE_FIRST_GATE_ENABLE  = 3;
  localparam int MODE_LSB1   = 4;
  localparam int MODE_CSEL1  = 6;
  localparam int MODE_GATE1  = 7;
  localparam int CLK_PRE_LSB = 0;
  localparam int CLK_SYS0    = 2;
  localparam int CLK_SYS1    = 3;
  localparam int EXT_POL0    = 3;
  localparam int EXT_POL1    = 7;
  localparam int IRQEN0      = 1;
  localparam int IRQEN1      = 3;

  // Count byte indices within the byte array
  localparam int CNT_LO0 = 0;
  localparam int CNT_HI0 = 1;
  localparam int CNT_LO1 = 2;
  localparam int CNT_HI1 = 3;

  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Modes and prescaler
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  localparam logic [1:0] PRE_DIV12  = 2'h0;
  localparam logic [1:0] PRE_DIV4   = 2'h1;
  localparam logic [1:0] PRE_DIV48  = 2'h2;
  localparam logic [1:0] PRE_EXT8   = 2'h3;
  localparam logic [5:0] DIV12_LAST = 6'h0b;
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV48_LAST = 6'h2f;
  localparam logic [2:0] EXT8_LAST  = 3'h7;

  localparam logic [12:0] MAX13 = 13'h1fff;

endpackage
